//--- stm_ctrl.v
// SDRAM timing and mode control: register, special init commands,
// and a simple one-access-at-a-time SDRAM command sequencer.
// Assumes an AXI4-Lite master and a host request port held until ack.
//
// Functional notes
// - Mode-register-set mode: each host cycle becomes an MRS command.
// - CAS_BEFORE_RAS_REFRESH mode: each host cycle becomes a CAS-before-RAS refresh.
// - Cycle-time bit: 0 gives 5/7 clocks, 1 gives 6/8.
// - Read latency bit: 0 gives three clocks, 1 gives two.
// - Activate-to-command bit: 0 gives three clocks, 1 gives two.
// - Precharge bit: 0 gives three clocks, 1 gives two.
// - Mode defaults to self-refresh; 001 and 010 refresh normally.
// - NOP mode: each host cycle becomes a no-operation command.
// - Precharge mode: each host cycle becomes all-bank precharge.
`include "stm_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module stm_ctrl #(
  parameter REF156 = `STM_REF156_CYC,
  parameter REF78 = `STM_REF78_CYC
) (
  // Clock, enable, reset
  input wire REF_CLK,
  input wire CE,
  input wire RST,
  // AXI4-Lite slave
  input wire [3:0] AWADDR,
  input wire AWVALID,
  output reg AWREADY,
  input wire [31:0] WDATA,
  input wire [3:0] WSTRB,
  input wire WVALID,
  output reg WREADY,
  output reg [1:0] BRESP,
  output reg BVALID,
  input wire BREADY,
  input wire [3:0] ARADDR,
  input wire ARVALID,
  output reg ARREADY,
  output reg [31:0] RDATA,
  output reg [1:0] RRESP,
  output reg RVALID,
  input wire RREADY,
  // Host access port
  input wire HOST_REQ,
  input wire HOST_WR,
  input wire [13:0] HOST_ADDR,
  output reg HOST_ACK,
  output reg HOST_RDATA_VLD,
  // SDRAM side
  output reg [3:0] MEM_CMD,
  output reg [11:0] MEM_ADDR_BUS_A,
  output reg [11:0] INVERTED_MEM_ADDR_COPY,
  output reg MEM_BANK_SELECT,
  output reg MEM_CKE
);

  // -------------------------------------------------------------
  // Register state
  // -------------------------------------------------------------
  reg [7:0] ctrl;
  reg aw_got, w_got;
  reg [3:0] aw_q;
  reg [7:0] w_q;
  reg w_lane;
  wire [2:0] dram_op_mode_sel = ctrl[`STM_MODE_HI:`STM_MODE_LO];

  // Bus write: address and data taken in either order
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ctrl <= `STM_CTRL_RST;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_q <= 4'h0;
      w_q <= 8'h00;
      w_lane <= 1'b0;
      AWREADY <= 1'b1;
      WREADY <= 1'b1;
      BVALID <= 1'b0;
      BRESP <= 2'b00;
    end else if (CE) begin
      if (AWVALID && AWREADY) begin
        aw_q <= AWADDR;
        aw_got <= 1'b1;
        AWREADY <= 1'b0;
      end
      if (WVALID && WREADY) begin
        w_q <= WDATA[7:0];
        w_lane <= WSTRB[0];
        w_got <= 1'b1;
        WREADY <= 1'b0;
      end
      if (aw_got && w_got && !BVALID) begin
        BVALID <= 1'b1;
        BRESP <= (aw_q == `STM_OFF_CTRL || aw_q == `STM_OFF_STAT) ?
                 2'b00 : 2'b10;
        if (aw_q == `STM_OFF_CTRL && w_lane)
          ctrl <= w_q & `STM_CTRL_WMASK;
      end
      if (BVALID && BREADY) begin
        BVALID <= 1'b0;
        aw_got <= 1'b0;
        w_got <= 1'b0;
        AWREADY <= 1'b1;
        WREADY <= 1'b1;
      end
    end
  end

  // -------------------------------------------------------------
  // Sequencer
  // -------------------------------------------------------------
  localparam S_IDLE = 3'd0;
  localparam S_ACT = 3'd1;
  localparam S_RW = 3'd2;
  localparam S_LAT = 3'd3;
  localparam S_PRE = 3'd4;
  localparam S_SPEC = 3'd5;
  reg [2:0] state;
  reg [3:0] cnt;
  reg [3:0] ras_left;
  reg [3:0] t_cl, t_rp;
  reg [13:0] ref_cnt;
  reg ref_due;
  reg is_wr, pre_sent;
  wire normal = (dram_op_mode_sel == `STM_MODE_N156) ||
                (dram_op_mode_sel == `STM_MODE_N78);
  wire [13:0] ref_lim = (dram_op_mode_sel == `STM_MODE_N78) ?
                        REF78[13:0] : REF156[13:0];
  wire ref_wrap = normal && (ref_cnt >= ref_lim - 14'h0001);

  // Command, address and timing latch per access
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      state <= S_IDLE;
      cnt <= 4'h0;
      ras_left <= 4'h0;
      t_cl <= `STM_T3;
      t_rp <= `STM_T3;
      pre_sent <= 1'b0;
      ref_cnt <= 14'h0000;
      ref_due <= 1'b0;
      is_wr <= 1'b0;
      HOST_ACK <= 1'b0;
      HOST_RDATA_VLD <= 1'b0;
      MEM_CMD <= `STM_CMD_NOP;
      MEM_ADDR_BUS_A <= 12'h000;
      INVERTED_MEM_ADDR_COPY <= 12'hFFF;
      MEM_BANK_SELECT <= 1'b0;
      MEM_CKE <= 1'b0;
    end else if (CE) begin
      HOST_ACK <= 1'b0;
      HOST_RDATA_VLD <= 1'b0;
      MEM_CMD <= `STM_CMD_NOP;
      // periodic refresh only in normal modes
      if (!normal || ref_wrap)
        ref_cnt <= 14'h0000;
      else
        ref_cnt <= ref_cnt + 14'h0001;
      ref_due <= ref_due | ref_wrap;
      // Self-refresh keeps clock enable low
      MEM_CKE <= (dram_op_mode_sel != `STM_MODE_SELF);
      if (ras_left != 4'h0)
        ras_left <= ras_left - 4'h1;
      if (cnt != 4'h0)
        cnt <= cnt - 4'h1;
      case (state)
        S_IDLE: begin
          if (cnt == 4'h0 && ras_left == 4'h0) begin // tRP has run out
            // timing latched in every idle cycle once tRP has run out
            t_cl <= ctrl[`STM_LAT_BIT] ? `STM_T2 : `STM_T3;
            t_rp <= ctrl[`STM_PRE_BIT] ? `STM_T2 : `STM_T3;
            if (normal && ref_due) begin
              ref_due <= ref_wrap; // a new period due now wins
              MEM_CMD <= `STM_CMD_REF;
              cnt <= (ctrl[`STM_CYC_BIT] ? `STM_TRC_1 : `STM_TRC_0) - 4'h1;
            end else if (HOST_REQ && normal) begin
              MEM_CMD <= `STM_CMD_ACT;
              MEM_BANK_SELECT <= HOST_ADDR[13];
              MEM_ADDR_BUS_A <= HOST_ADDR[11:0];
              INVERTED_MEM_ADDR_COPY <= ~HOST_ADDR[11:0];
              is_wr <= HOST_WR;
              pre_sent <= 1'b0;
              cnt <= (ctrl[`STM_ACT_BIT] ? `STM_T2 : `STM_T3) - 4'h1;
              ras_left <= (ctrl[`STM_CYC_BIT] ? `STM_TRAS_1 :
                           `STM_TRAS_0) - 4'h1;
              state <= S_ACT;
            end else if (HOST_REQ && dram_op_mode_sel[2]) begin
              MEM_BANK_SELECT <= HOST_ADDR[12];
              MEM_ADDR_BUS_A <= HOST_ADDR[11:0];
              INVERTED_MEM_ADDR_COPY <= ~HOST_ADDR[11:0];
              case (dram_op_mode_sel)
                `STM_MODE_NOP: MEM_CMD <= `STM_CMD_NOP;
                `STM_MODE_PRE: begin
                  MEM_CMD <= `STM_CMD_PRE;
                  MEM_ADDR_BUS_A <= HOST_ADDR[11:0] | 12'h400;
                  INVERTED_MEM_ADDR_COPY <= ~(HOST_ADDR[11:0] | 12'h400);
                end
                // mode register set from host address
                `STM_MODE_MRS: MEM_CMD <= `STM_CMD_MRS;
                default: MEM_CMD <= `STM_CMD_REF;
              endcase
              HOST_ACK <= 1'b1;
              cnt <= `STM_T2;
              state <= S_SPEC;
            end
          end
        end
        S_ACT: begin
          if (cnt == 4'h0) begin
            MEM_CMD <= is_wr ? `STM_CMD_WR : `STM_CMD_RD;
            MEM_ADDR_BUS_A <= {2'b00, HOST_ADDR[11:10] & 2'b10,
                               HOST_ADDR[7:0]};
            INVERTED_MEM_ADDR_COPY <= ~{2'b00, HOST_ADDR[11:10] & 2'b10,
                                        HOST_ADDR[7:0]};
            HOST_ACK <= is_wr;
            cnt <= is_wr ? 4'h0 : t_cl - 4'h1;
            state <= is_wr ? S_PRE : S_LAT;
          end
        end
        S_LAT: begin
          if (ras_left == 4'h0 && !pre_sent) begin // row closes early
            MEM_CMD <= `STM_CMD_PRE;
            ras_left <= t_rp - 4'h1;
            pre_sent <= 1'b1;
          end
          if (cnt == 4'h0) begin
            HOST_RDATA_VLD <= 1'b1;
            HOST_ACK <= 1'b1;
            state <= S_PRE;
          end
        end
        S_PRE: begin
          if (pre_sent)
            state <= S_IDLE;
          else if (ras_left == 4'h0) begin
            MEM_CMD <= `STM_CMD_PRE;
            ras_left <= t_rp - 4'h1;
            state <= S_IDLE;
          end
        end
        S_SPEC: begin
          // Wait for the host to drop its request before the next one
          if (cnt == 4'h0 && !HOST_REQ)
            state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Bus read of control and live status
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ARREADY <= 1'b1;
      RVALID <= 1'b0;
      RDATA <= 32'h0000_0000;
      RRESP <= 2'b00;
    end else if (CE) begin
      if (ARVALID && ARREADY) begin
        ARREADY <= 1'b0;
        RVALID <= 1'b1;
        RRESP <= 2'b00;
        if (ARADDR == `STM_OFF_CTRL)
          RDATA <= {24'h00_0000, ctrl};
        else if (ARADDR == `STM_OFF_STAT)
          RDATA <= {24'h00_0000, ref_due, MEM_CKE, 3'b000, state};
        else begin
          RDATA <= 32'h0000_0000;
          RRESP <= 2'b10;
        end
      end else if (RVALID && RREADY) begin
        RVALID <= 1'b0;
        ARREADY <= 1'b1;
      end
    end
  end

endmodule // stm_ctrl
`default_nettype wire

//--- stm_defines.vh
// Constants for the SDRAM timing and mode control block.
// Assumes inclusion by bare name from the design file.
`ifndef STM_DEFINES_VH
`define STM_DEFINES_VH
// -------------------------------------------------------------
// Register offsets (byte addresses on the bus)
// -------------------------------------------------------------
`define STM_OFF_CTRL 4'h0
`define STM_OFF_STAT 4'h4
// -------------------------------------------------------------
// Control register fields and reset value
// -------------------------------------------------------------
`define STM_MODE_HI 7
`define STM_MODE_LO 5
`define STM_CYC_BIT 4
`define STM_LAT_BIT 2
`define STM_ACT_BIT 1
`define STM_PRE_BIT 0
`define STM_CTRL_RST 8'h00
`define STM_CTRL_WMASK 8'hF7
// -------------------------------------------------------------
// Mode-select codes
// -------------------------------------------------------------
`define STM_MODE_SELF 3'h0
`define STM_MODE_N156 3'h1
`define STM_MODE_N78 3'h2
`define STM_MODE_RSVD 3'h3
`define STM_MODE_NOP 3'h4
`define STM_MODE_PRE 3'h5
`define STM_MODE_MRS 3'h6
`define STM_MODE_CBR 3'h7
// -------------------------------------------------------------
// SDRAM commands {cs_n, ras_n, cas_n, we_n}
// -------------------------------------------------------------
`define STM_CMD_DESEL 4'h8
`define STM_CMD_NOP 4'h7
`define STM_CMD_ACT 4'h3
`define STM_CMD_RD 4'h5
`define STM_CMD_WR 4'h4
`define STM_CMD_PRE 4'h2
`define STM_CMD_REF 4'h1
`define STM_CMD_MRS 4'h0
// -------------------------------------------------------------
// Timing figures in SDRAM clocks
// -------------------------------------------------------------
`define STM_TRAS_0 4'h5
`define STM_TRAS_1 4'h6
`define STM_TRC_0 4'h7
`define STM_TRC_1 4'h8
`define STM_T3 4'h3
`define STM_T2 4'h2
// Refresh intervals in ns, counts derived at 50 ns per clock
`define STM_REF156_NS 15600
`define STM_REF78_NS 7800
`define STM_CLK_NS 50
`define STM_REF156_CYC (`STM_REF156_NS / `STM_CLK_NS)
`define STM_REF78_CYC (`STM_REF78_NS / `STM_CLK_NS)
`endif

//--- stm_sdram_model.sv
// SDRAM device model: keeps the mode word and counts refreshes.
// Assumes commands on the edge after the controller drives them.
`timescale 1ns/1ps
`default_nettype none
`include "stm_defines.vh"
module stm_sdram_model (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // Command and address lines
  input wire logic [3:0] MEM_CMD,
  input wire logic [11:0] MEM_ADDR_BUS_A,
  input wire logic MEM_BANK_SELECT,
  // Observed state
  output logic [12:0] mode_reg,
  output logic [7:0] ref_cnt
);
  // Mode word loads whole, bank bit on top
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      mode_reg <= 13'h0000;
      ref_cnt <= 8'h00;
    end else begin
      if (MEM_CMD === `STM_CMD_MRS)
        mode_reg <= {MEM_BANK_SELECT, MEM_ADDR_BUS_A};
      if (MEM_CMD === `STM_CMD_REF)
        ref_cnt <= ref_cnt + 8'h01;
    end
  end
endmodule // stm_sdram_model
`default_nettype wire

//--- stm_ctrl_assertions.sv
// Checker for stm_ctrl: command timing and host handshake.
// Assumes binding to the top module's ports.
`timescale 1ns/1ps
`default_nettype none
`include "stm_defines.vh"
module stm_ctrl_chk (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // Host side
  input wire logic [13:0] HOST_ADDR,
  input wire logic HOST_ACK,
  input wire logic HOST_RDATA_VLD,
  // SDRAM side
  input wire logic [3:0] MEM_CMD,
  input wire logic [11:0] MEM_ADDR_BUS_A,
  input wire logic [11:0] INVERTED_MEM_ADDR_COPY,
  input wire logic MEM_BANK_SELECT
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  AST_INV_COPY: assert property (
    INVERTED_MEM_ADDR_COPY == ~MEM_ADDR_BUS_A)
    else $error("second copy not inverse");
  AST_ACT_CMD: assert property (MEM_CMD == `STM_CMD_ACT |->
    ##[2:3] (MEM_CMD == `STM_CMD_RD || MEM_CMD == `STM_CMD_WR))
    else $error("activate to command gap wrong");
  AST_RD_VLD: assert property (
    MEM_CMD == `STM_CMD_RD |-> ##[2:3] HOST_RDATA_VLD)
    else $error("read sample point wrong");
  AST_ACT_PRE: assert property (
    MEM_CMD == `STM_CMD_ACT |-> ##[5:6] MEM_CMD == `STM_CMD_PRE)
    else $error("active time wrong");
  AST_PRE_GAP: assert property (
    MEM_CMD == `STM_CMD_PRE |=> MEM_CMD != `STM_CMD_ACT)
    else $error("precharge time too short");
  AST_ACK_ONE: assert property (HOST_ACK |=> !HOST_ACK)
    else $error("ack longer than one cycle");
  AST_ACK_CMD: assert property (HOST_ACK |-> MEM_CMD inside
    {`STM_CMD_MRS, `STM_CMD_REF, `STM_CMD_PRE, `STM_CMD_NOP, `STM_CMD_WR})
    else $error("ack without its command");
  AST_MRS_ADDR: assert property (MEM_CMD == `STM_CMD_MRS |->
    {MEM_BANK_SELECT, MEM_ADDR_BUS_A} == $past(HOST_ADDR[12:0]))
    else $error("mode word not host address");
  // Main scenarios reached
  cover property (MEM_CMD == `STM_CMD_MRS);
  cover property (MEM_CMD == `STM_CMD_REF);
  cover property (HOST_RDATA_VLD);
endmodule // stm_ctrl_chk
`default_nettype wire

//--- tb_top.sv
// Testbench for stm_ctrl: registers, init commands, timing.
// Assumes the controller, SDRAM model and checker are compiled.
`timescale 1ns/1ps
`default_nettype none
`include "stm_defines.vh"
module tb_top;
  logic REF_CLK = 1'b0;
  logic RST = 1'b1;
  logic [3:0] AWADDR = 4'h0, ARADDR = 4'h0, WSTRB = 4'hF;
  logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0;
  logic RREADY = 1'b0, HOST_REQ = 1'b0, HOST_WR = 1'b0, CE = 1'b1;
  logic [31:0] WDATA = 32'h0000_0000;
  logic [13:0] HOST_ADDR = 14'h0000;
  wire AWREADY, WREADY, BVALID, ARREADY, RVALID, HOST_ACK;
  wire HOST_RDATA_VLD, MEM_BANK_SELECT, MEM_CKE;
  wire [1:0] BRESP, RRESP;
  wire [31:0] RDATA;
  wire [3:0] MEM_CMD;
  wire [11:0] MEM_ADDR_BUS_A, INVERTED_MEM_ADDR_COPY;
  wire [12:0] mode_reg;
  wire [7:0] ref_cnt;
  int n_fail = 0, comparisons = 0, cyc = 0, t_act, t_rd, t_pre, t_vld;
  logic [1:0] r;
  logic [31:0] d;
  logic [3:0] c;
  logic [12:0] ab;
  // Small refresh counts keep the run short
  stm_ctrl #(.REF156(40), .REF78(20)) u_stm_ctrl (
    .REF_CLK(REF_CLK), .CE(CE), .RST(RST),
    .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
    .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
    .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .HOST_REQ(HOST_REQ), .HOST_WR(HOST_WR), .HOST_ADDR(HOST_ADDR),
    .HOST_ACK(HOST_ACK), .HOST_RDATA_VLD(HOST_RDATA_VLD),
    .MEM_CMD(MEM_CMD), .MEM_ADDR_BUS_A(MEM_ADDR_BUS_A),
    .INVERTED_MEM_ADDR_COPY(INVERTED_MEM_ADDR_COPY),
    .MEM_BANK_SELECT(MEM_BANK_SELECT), .MEM_CKE(MEM_CKE));
  stm_sdram_model u_stm_sdram_model (.REF_CLK(REF_CLK), .RST(RST),
    .MEM_CMD(MEM_CMD), .MEM_ADDR_BUS_A(MEM_ADDR_BUS_A),
    .MEM_BANK_SELECT(MEM_BANK_SELECT), .mode_reg(mode_reg),
    .ref_cnt(ref_cnt));
  always #25 REF_CLK = ~REF_CLK;
  // Event stamps; the hang limit is well above the test length
  always @(posedge REF_CLK) begin
    cyc <= cyc + 1;
    if (MEM_CMD === `STM_CMD_ACT) t_act <= cyc;
    if (MEM_CMD === `STM_CMD_RD) t_rd <= cyc;
    if (MEM_CMD === `STM_CMD_PRE) t_pre <= cyc;
    if (HOST_RDATA_VLD === 1'b1) t_vld <= cyc;
    if (cyc == 20000) begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      n_fail++;
    end
  endtask
  // Bus write: address and data offered together, held until taken
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    AWADDR <= a;
    WDATA <= v;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(posedge REF_CLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end while (BVALID !== 1'b1);
    r = BRESP;
    BREADY <= 1'b0;
    // Idle edge keeps back-to-back calls from re-driving ready at once
    @(posedge REF_CLK);
  endtask
  task automatic rd(input logic [3:0] a);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(posedge REF_CLK);
      if (ARREADY) ARVALID <= 1'b0;
    end while (RVALID !== 1'b1);
    d = RDATA;
    r = RRESP;
    RREADY <= 1'b0;
    @(posedge REF_CLK);
  endtask
  // Host cycle held until acknowledged, then the required idle gap
  task automatic host(input logic [13:0] a, input logic w);
    HOST_ADDR <= a;
    HOST_WR <= w;
    HOST_REQ <= 1'b1;
    do @(posedge REF_CLK);
    while (HOST_ACK !== 1'b1 && HOST_RDATA_VLD !== 1'b1);
    c = MEM_CMD;
    ab = {MEM_BANK_SELECT, MEM_ADDR_BUS_A};
    HOST_REQ <= 1'b0;
    repeat (3) @(posedge REF_CLK);
  endtask
  task automatic s_regs();
    rd(`STM_OFF_CTRL);
    chk(d, 32'h0000_0000);
    chk(r, 2'h0);
    wr(`STM_OFF_CTRL, 32'h0000_00FF);
    chk(r, 2'h0);
    rd(`STM_OFF_CTRL);
    chk(d, 32'h0000_00F7);
    // Live status: clock enable up outside self-refresh, sequencer idle
    rd(`STM_OFF_STAT);
    chk(d, 32'h0000_0040);
    wr(4'hC, 32'h0000_0000);
    chk(r, 2'h2);
    rd(4'hC);
    chk(r, 2'h2);
    chk(d, 32'h0000_0000);
    rd(`STM_OFF_CTRL);
    chk(d, 32'h0000_00F7);
  endtask
  // Each special mode turns one host cycle into its command
  task automatic s_special();
    logic [7:0] ctl [5] = '{8'h80, 8'hA0, 8'hC0, 8'hC4, 8'hE0};
    logic [3:0] ex [5] = '{`STM_CMD_NOP, `STM_CMD_PRE, `STM_CMD_MRS,
                           `STM_CMD_MRS, `STM_CMD_REF};
    logic [13:0] a;
    for (int i = 0; i < 5; i++) begin
      // Burst 4, interleaved, latency bit, high bits low
      a = (i == 3) ? 14'h003A : 14'h002A;
      wr(`STM_OFF_CTRL, {24'h00_0000, ctl[i]});
      host(a, 1'b0);
      chk(c, ex[i]);
      if (i == 2 || i == 3) chk(mode_reg, a[12:0]);
    end
  endtask
  // Normal read timing and write command for both settings of the bits
  task automatic s_timing();
    for (int b = 0; b < 2; b++) begin
      wr(`STM_OFF_CTRL, b ? 32'h0000_0037 : 32'h0000_0020);
      host(14'h0123, 1'b0);
      repeat (4) @(posedge REF_CLK);
      chk(t_rd - t_act, b ? 2 : 3);
      chk(t_vld - t_rd, b ? 2 : 3);
      chk(t_pre - t_act, b ? 6 : 5);
      host(14'h0456, 1'b1);
      chk(c, `STM_CMD_WR);
    end
  endtask
  // Self-refresh ignores the host; normal modes refresh on time
  task automatic s_power();
    int k;
    wr(`STM_OFF_CTRL, 32'h0000_0000);
    chk(MEM_CKE, 1'b0);
    HOST_REQ <= 1'b1;
    k = 0;
    repeat (10) begin
      @(posedge REF_CLK);
      if (HOST_ACK !== 1'b0) k++;
    end
    HOST_REQ <= 1'b0;
    chk(k, 0);
    // Frozen block leaves a read unanswered until enabled again
    CE <= 1'b0;
    ARADDR <= `STM_OFF_CTRL;
    ARVALID <= 1'b1;
    repeat (5) @(posedge REF_CLK);
    chk(RVALID, 1'b0);
    CE <= 1'b1;
    rd(`STM_OFF_CTRL);
    chk(d, 32'h0000_0000);
    for (int m = 1; m < 3; m++) begin
      wr(`STM_OFF_CTRL, {24'h00_0000, 1'b0, m[1], m[0], 5'h00});
      k = ref_cnt;
      repeat (100) @(posedge REF_CLK);
      chk(MEM_CKE, 1'b1);
      chk((ref_cnt - k) inside {[m * 2 + m - 1:m * 2 + m]}, 1);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge REF_CLK);
    RST <= 1'b0;
    s_regs();
    s_special();
    s_timing();
    s_power();
    give_verdict();
  end
endmodule // tb_top
bind stm_ctrl stm_ctrl_chk u_stm_ctrl_chk (.REF_CLK(REF_CLK),
  .RST(RST), .HOST_ADDR(HOST_ADDR), .HOST_ACK(HOST_ACK),
  .HOST_RDATA_VLD(HOST_RDATA_VLD), .MEM_CMD(MEM_CMD),
  .MEM_ADDR_BUS_A(MEM_ADDR_BUS_A),
  .INVERTED_MEM_ADDR_COPY(INVERTED_MEM_ADDR_COPY),
  .MEM_BANK_SELECT(MEM_BANK_SELECT));
`default_nettype wire
